/* File: hw/up_counter_consts.svh */
// Offsets, field positions, reset values and widths for the preset up counter
`ifndef UP_COUNTER_CONSTS_SVH
`define UP_COUNTER_CONSTS_SVH

// ----------------------------------------------------------------------------
// Counter geometry
// ----------------------------------------------------------------------------
`define COUNT_W 4
`define COUNT_ZERO 4'h0
`define COUNT_ONE 4'h1
`define COUNT_FULL 4'hf

// ----------------------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------------------
`define APB_ADDR_W 12
`define OFF_STATUS 12'h000
`define OFF_SW_LOAD 12'h004

// Status register field positions
`define ST_COUNT_LSB 0
`define ST_TC_BIT 4
`define ST_CE_BIT 5
`define ST_LOAD_BIT 6

// Reset values
`define RST_PRDATA 32'h0000_0000
`define RST_SW_VALUE 4'h0

`endif

/* File: hw/up_counter_pkg.sv */
// Types shared by the preset up counter
`default_nettype none

package up_counter_pkg;
`include "up_counter_consts.svh"

    // Next-edge action of the counter
    typedef enum logic [1:0] {
        MODE_HOLD,
        MODE_COUNT,
        MODE_LOAD,
        MODE_SW_LOAD
    } mode_t;

    // Whole registered state of the counter block
    typedef struct packed {
        logic [`COUNT_W-1:0] count;
        logic [`COUNT_W-1:0] sw_value;
        logic sw_load;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;

    // Control inputs that travel together from the driving logic
    typedef struct packed {
        logic parallel_load_n;
        logic count_enable_par;
        logic count_enable_carry;
        logic [`COUNT_W-1:0] preset;
    } ctrl_t;

endpackage

`default_nettype wire

/* File: hw/up_counter.sv */
// Four-bit presettable synchronous binary up counter with APB status access
//
// Contract
// RULE1 - Outputs change together only on the rising clock edge, except clear.
// RULE2 - Enabled and not loading, each edge advances to the next binary value.
// RULE3 - Load low copies the preset inputs on the next edge, enables ignored.
// RULE4 - Load high and enable high counts; enable low holds; load low presets.
// RULE5 - Combined enable is parallel enable AND carry enable.
// RULE6 - Terminal count high only with carry enable high and all bits high.
// RULE7 - Active-low clear zeroes the count at once, over every other input.
// RULE8 - Driving logic drops enables or raises load only while clock high.
// RULE9 - Cascade: terminal count feeds next stage enables for synchronous counting.
// RULE10 - From all ones the counter wraps to zero on the next enabled edge.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "up_counter_consts.svh"

module up_counter
    import up_counter_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic clear_n,
    input wire ctrl_t ctrl,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [`COUNT_W-1:0] count,
    output logic terminal_count
);

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------

    // Next-edge mode; the load pin outranks the software load
    function automatic mode_t mode_of(input logic load_n, input logic ce,
                                      input logic sw_ld);
        mode_t m;
        m = MODE_HOLD;
        if (!load_n) begin
            m = MODE_LOAD;
        end else if (sw_ld) begin
            m = MODE_SW_LOAD;
        end else if (ce) begin
            m = MODE_COUNT;
        end
        return m;
    endfunction

    // Terminal count decode, also used for the status word
    function automatic logic tc_of(input logic carry_en,
                                   input logic [`COUNT_W-1:0] value);
        return carry_en && (value == `COUNT_FULL);
    endfunction

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    state_t st;
    state_t next_st;
    logic count_en;
    mode_t mode;
    logic setup_phase;
    logic [31:0] status_word;

    // Combined enable of both count enables
    assign count_en = ctrl.count_enable_par && ctrl.count_enable_carry; // see RULE5

    // Mode decode for the coming edge
    assign mode = mode_of(ctrl.parallel_load_n, count_en, st.sw_load); // see RULE4

    // A transfer is in its first cycle
    assign setup_phase = psel && !penable;

    // Status word assembled from the live counter state
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`ST_COUNT_LSB +: `COUNT_W] = st.count;
        status_word[`ST_TC_BIT] = tc_of(ctrl.count_enable_carry, st.count);
        status_word[`ST_CE_BIT] = count_en;
        status_word[`ST_LOAD_BIT] = !ctrl.parallel_load_n;
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------

    // Counter action, then the APB slave
    always_comb begin
        next_st = st;
        next_st.sw_load = 1'b0;
        case (mode)
            MODE_LOAD: begin
                next_st.count = ctrl.preset; // see RULE3
            end
            MODE_SW_LOAD: begin
                next_st.count = st.sw_value;
            end
            MODE_COUNT: begin
                // Plain binary step; all ones rolls over to zero
                next_st.count = st.count + `COUNT_ONE; // see RULE2, RULE10
            end
            default: begin
                next_st.count = st.count;
            end
        endcase

        // Ready rises in the access cycle and drops after the handshake
        next_st.pready = psel && !st.pready;
        // Answer fields stand for the access cycle only, then fall back to idle
        next_st.pslverr = 1'b0;
        next_st.prdata = `RST_PRDATA;
        if (setup_phase) begin
            if (paddr == `OFF_STATUS) begin
                if (!pwrite) begin
                    next_st.prdata = status_word;
                end
            end else if (paddr == `OFF_SW_LOAD) begin
                if (!pwrite) begin
                    next_st.prdata = {{(32-`COUNT_W){1'b0}}, st.sw_value};
                end
            end else begin
                next_st.pslverr = 1'b1; // Unmapped address
            end
        end

        // Write takes effect on the completing edge only
        if (psel && penable && st.pready && pwrite && !st.pslverr) begin
            if (paddr == `OFF_SW_LOAD) begin
                next_st.sw_value = pwdata[`COUNT_W-1:0];
                next_st.sw_load = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------

    // Clear acts without the clock and wins over everything else
    always_ff @(posedge clk or negedge clear_n) begin
        if (!clear_n) begin
            st <= '0; // see RULE7
        end else if (srst) begin
            st <= '0;
        end else begin
            st <= next_st; // see RULE1
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------

    // Bus and count straight from the state register
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign count = st.count;

    // Carry-out gated by the carry enable so stages chain synchronously
    assign terminal_count = tc_of(ctrl.count_enable_carry, st.count); // see RULE6, RULE9

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------

    // Load low always presets on the next edge
    chk_load_copies: assert property ( // see RULE3
        @(posedge clk) disable iff (srst || !clear_n)
        !ctrl.parallel_load_n |=> count == $past(ctrl.preset)
    ) else $error("load did not copy the preset value");

    // Counting steps by exactly one
    chk_count_step: assert property ( // see RULE2
        @(posedge clk) disable iff (srst || !clear_n)
        (ctrl.parallel_load_n && !st.sw_load && ctrl.count_enable_par
            && ctrl.count_enable_carry)
        |=> count == $past(count) + `COUNT_ONE
    ) else $error("enabled count did not advance by one");

    // Enable low with load high holds the value
    chk_hold_value: assert property ( // see RULE4
        @(posedge clk) disable iff (srst || !clear_n)
        (ctrl.parallel_load_n && !st.sw_load && !count_en) |=> $stable(count)
    ) else $error("count moved while disabled");

    // Parallel enable alone never counts
    chk_enable_and: assert property ( // see RULE5
        @(posedge clk) disable iff (srst || !clear_n)
        (ctrl.parallel_load_n && !st.sw_load && ctrl.count_enable_par
            && !ctrl.count_enable_carry)
        |=> count == $past(count)
    ) else $error("count moved with carry enable low");

    // All ones wraps to zero
    chk_wrap_zero: assert property ( // see RULE10
        @(posedge clk) disable iff (srst || !clear_n)
        (count == `COUNT_FULL && ctrl.parallel_load_n && !st.sw_load && count_en)
        |=> count == `COUNT_ZERO
    ) else $error("counter did not wrap to zero");

    // Terminal count implies full count and carry enable
    chk_tc_full: assert property ( // see RULE6
        @(posedge clk) disable iff (srst || !clear_n)
        terminal_count |-> (count == `COUNT_FULL) && ctrl.count_enable_carry
    ) else $error("terminal count without full count");

    // Stepping from fourteen with carry held raises terminal count
    chk_tc_cascade: assert property ( // see RULE9
        @(posedge clk) disable iff (srst || !clear_n)
        (count == 4'he && ctrl.parallel_load_n && !st.sw_load && count_en)
        ##1 ctrl.count_enable_carry |-> terminal_count
    ) else $error("terminal count missing for cascade");

    // Clear holds the count at zero
    chk_clear_zero: assert property ( // see RULE7
        @(posedge clk) disable iff (srst)
        !clear_n |-> count == `COUNT_ZERO
    ) else $error("count not zero under clear");

    // Count only changes for a documented cause
    chk_change_cause: assert property ( // see RULE1
        @(posedge clk) disable iff (!clear_n)
        $changed(count) |-> $past(srst || !ctrl.parallel_load_n || st.sw_load
            || count_en)
    ) else $error("count changed without cause");

    // Bus answers in the first cycle of the access phase
    chk_apb_answer: assert property (
        @(posedge clk) disable iff (srst || !clear_n)
        (psel && !penable) ##1 (psel && penable) |-> pready
    ) else $error("no ready in first access cycle");

    // Ready is a single-cycle answer
    chk_ready_pulse: assert property (
        @(posedge clk) disable iff (srst || !clear_n)
        pready |=> !pready
    ) else $error("ready stood for more than one cycle");

    // Ready only answers an access cycle
    chk_ready_in_access: assert property (
        @(posedge clk) disable iff (srst || !clear_n)
        pready |-> psel && penable
    ) else $error("ready outside an access cycle");

    // Unmapped addresses answer with an error
    chk_unmapped_error: assert property (
        @(posedge clk) disable iff (srst || !clear_n)
        (setup_phase && paddr != `OFF_STATUS && paddr != `OFF_SW_LOAD)
        |=> pready && pslverr
    ) else $error("unmapped address gave no error");

    // Mapped addresses answer without an error
    chk_mapped_ok: assert property (
        @(posedge clk) disable iff (srst || !clear_n)
        (setup_phase && (paddr == `OFF_STATUS || paddr == `OFF_SW_LOAD))
        |=> pready && !pslverr
    ) else $error("mapped address gave an error");

    // Read data and error return to idle outside the answer
    chk_answer_idle: assert property (
        @(posedge clk) disable iff (srst || !clear_n)
        !pready |-> prdata == `RST_PRDATA && !pslverr
    ) else $error("bus answer held outside its cycle");

    // Status read shows the count of the setup cycle
    chk_status_count: assert property (
        @(posedge clk) disable iff (srst || !clear_n)
        (setup_phase && !pwrite && paddr == `OFF_STATUS)
        |=> prdata[`ST_COUNT_LSB +: `COUNT_W] == $past(count)
    ) else $error("status read returned a stale count");

    // Status read shows the terminal count of the setup cycle
    chk_status_tc: assert property ( // see RULE6
        @(posedge clk) disable iff (srst || !clear_n)
        (setup_phase && !pwrite && paddr == `OFF_STATUS)
        |=> prdata[`ST_TC_BIT] == $past(terminal_count)
    ) else $error("status read returned a stale terminal count");

    // Software load reaches the count one edge after the write
    chk_sw_load_apply: assert property (
        @(posedge clk) disable iff (srst || !clear_n)
        (psel && penable && pready && pwrite && !pslverr && paddr == `OFF_SW_LOAD)
        ##1 ctrl.parallel_load_n |=> count == $past(pwdata[`COUNT_W-1:0], 2)
    ) else $error("software load value not applied");

    // Full count with carry enable always shows terminal count
    chk_tc_live: assert property ( // see RULE6
        @(posedge clk) disable iff (srst || !clear_n)
        (ctrl.count_enable_carry && count == `COUNT_FULL) |-> terminal_count
    ) else $error("terminal count missing at full count");

    // Synchronous reset zeroes the count and the bus answer
    chk_srst_zero: assert property (
        @(posedge clk) disable iff (!clear_n)
        srst |=> count == `COUNT_ZERO && !pready
    ) else $error("reset did not clear the counter");

endmodule

`default_nettype wire

/* File: tb/ctrl_source.sv */
// Model of the driving logic: control inputs plus one upstream cascade stage
`timescale 1ns/100ps
`default_nettype none

module ctrl_source
    import up_counter_pkg::*;
(
    input wire logic clk,
    input wire logic cascade,
    input wire ctrl_t want,
    output var ctrl_t ctrl
);
    logic [3:0] up = 4'h0;
    ctrl_t next_ctrl;

    // Changes land just after the rising edge, while the clock is still high
    always @(posedge clk) begin
        next_ctrl = want;
        // Upstream stage terminal count feeds both enables of this stage
        if (cascade) begin
            next_ctrl.count_enable_carry = (up == 4'he);
            next_ctrl.count_enable_par = (up == 4'he);
        end
        up <= up + 4'h1;
        ctrl <= next_ctrl;
    end
endmodule

`default_nettype wire

/* File: tb/up_counter_test.sv */
// Self-checking bench for the preset up counter
`timescale 1ns/100ps
`default_nettype none

module up_counter_test import up_counter_pkg::*;;
    logic clk, srst, clear_n, cascade, psel, penable, pwrite, pready, pslverr, tc;
    logic pend;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [3:0] count, exp, pval, e;
    logic [6:0] plan [6] = '{7'h3d, 7'h70, 7'h70, 7'h2f, 7'h50, 7'h60};
    ctrl_t want, ctrl;
    logic [3:0] cnt_q [$];
    logic [32:0] rd_q [$];
    int bad_count, comparisons, cycles;

    ctrl_source u_ctrl_source (.clk(clk), .cascade(cascade), .want(want), .ctrl(ctrl));
    up_counter u_up_counter (.clk(clk), .srst(srst), .clear_n(clear_n), .ctrl(ctrl),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .count(count),
        .terminal_count(tc));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [32:0] x, input logic [32:0] a);
        comparisons++;
        if (a !== x) begin
            bad_count++;
            $display("wrong value at %0t: expected %h got %h", $time, x, a);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // One APB transfer; reads note their expected word during the setup cycle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w,
        input logic [32:0] x);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= w;
        @(negedge clk);
        if (!wr) rd_q.push_back(a == 12'h000 ? {26'h0, ~ctrl.parallel_load_n,
            ctrl.count_enable_par & ctrl.count_enable_carry,
            ctrl.count_enable_carry & (exp == 4'hf), exp} : x);
        @(posedge clk);
        penable <= 1'b1;
        // Ready is sampled at the rising edge; the request stands until then
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reference count: one note per edge, plus the cycle ceiling
    always @(posedge clk) begin
        if (srst || !clear_n) begin
            exp = 4'h0;
            pend = 1'b0;
        end else if (!ctrl.parallel_load_n) begin
            exp = ctrl.preset;
            pend = 1'b0;
        end else if (pend) begin
            exp = pval;
            pend = 1'b0;
        end else if (ctrl.count_enable_par & ctrl.count_enable_carry) exp = exp + 4'h1;
        // A completed software-load write applies on the following edge
        if (psel && penable && pready && pwrite && paddr == 12'h004) begin
            pend = 1'b1;
            pval = pwdata[3:0];
        end
        cnt_q.push_back(exp);
        cycles++;
        if (cycles > 2000) begin
            bad_count++;
            results();
        end
    end

    // Compare outputs against the oldest notes
    always @(negedge clk) begin
        if (cnt_q.size() > 0) begin
            e = cnt_q.pop_front();
            if (!clear_n) e = 4'h0;
            check({29'h0, e}, {29'h0, count});
            check({32'h0, ctrl.count_enable_carry & (e == 4'hf)}, {32'h0, tc});
        end
        if (psel && penable && pready && !pwrite) check(rd_q.pop_front(), {pslverr, prdata});
    end

    initial begin
        {srst, clear_n, cascade, psel, penable, pwrite} = 6'b110000;
        paddr = 12'h000;
        pwdata = 32'h0;
        want = 7'h40;
        void'($urandom(83612));
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        repeat (300) begin
            @(posedge clk);
            want <= 7'($urandom);
        end
        $display("test random modes done");
        foreach (plan[i]) begin
            repeat (2) @(posedge clk);
            want <= plan[i];
        end
        $display("test wrap and terminal count done");
        @(posedge clk);
        cascade <= 1'b1;
        repeat (80) @(posedge clk);
        cascade <= 1'b0;
        $display("test cascade done");
        want <= 7'h40;
        d = $urandom;
        apb(1'b1, 12'h004, d, 33'h0);
        apb(1'b0, 12'h004, 32'h0, {29'h0, d[3:0]});
        apb(1'b1, 12'h000, 32'hffff_ffff, 33'h0);
        apb(1'b0, 12'h000, 32'h0, 33'h0);
        apb(1'b0, 12'h008, 32'h0, {1'b1, 32'h0});
        $display("test register access done");
        want <= 7'h2f;
        repeat (2) @(posedge clk);
        want <= 7'h3a;
        clear_n <= 1'b0;
        #1 check(33'h0, {29'h0, count});
        repeat (3) @(posedge clk);
        clear_n <= 1'b1;
        repeat (4) @(posedge clk);
        $display("test clear done");
        results();
    end
endmodule

`default_nettype wire
